// ===== logic/cmpc_pkg.sv
// constants, field layouts and carrier types of the clock manager phase-shift controller
// assumes one 10 MHz clock (pclk) runs the whole block, the phase-adjust and config ports included
// How it works
// - phase-adjust inputs taken on the rising clock edge
// - phase moves gradually, then one complete pulse
// - phase moves without glitches or sudden jumps
// - direction high increments, low decrements the phase
// - dynamic offset wraps at a full turn
// - complete stands one cycle, new adjustment allowed
// - integer output divide 1 to 128, 1 runs through the counter like the rest
// - only output 0 and feedback divide fractionally
// - outputs 0 to 3 have inverted copies
// - ref halted flag sets fast, clears after relock
// - feedback halted flag sets fast, clears after relock
// - lock drops within one detector cycle on faults
// - lock is acquired after power-on unaided
// - config read returns the addressed configuration cells
// - read data held until next config operation
// - acknowledge answers every config access strobe
// - feedback multiplier 2 to 64 in eighths, default 5
// - reference predivider 1 to 106, default 1
// - output static phase from -360 to 360 degrees
// - output high fraction 0.01 to 0.99, default half
// - feedback phase shifts all outputs negative
// - dynamic adjustment only with fine enable set
// - reset halts asynchronously, resumes on release
package cmpc_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned LOCK_TIME_NS  = 100_000;
    localparam int unsigned LOCK_CYC      = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PS_SETTLE_NS  = 1_000;
    localparam int unsigned PS_SETTLE_CYC = (PS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PS_WAIT_MAX   = 1100;

    // channel counts: outputs 0..6, feedback is channel 7
    localparam int unsigned NUM_OUT = 7;
    localparam int unsigned NUM_CH  = 8;
    localparam int unsigned NUM_INV = 4;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_FB     = 12'h008;
    localparam logic [11:0] ADDR_OUT0   = 12'h010;
    localparam logic [11:0] ADDR_OUT6   = 12'h028;

    // status word bit positions
    localparam int unsigned ST_LOCKED  = 0;
    localparam int unsigned ST_REFHALT = 1;
    localparam int unsigned ST_FBHALT  = 2;
    localparam int unsigned ST_BUSY    = 3;
    localparam int unsigned ST_PEND    = 8;

    // legal ranges, dividers and multiplier held in eighths
    localparam logic [10:0]        DIV8_MIN  = 11'h008;
    localparam logic [10:0]        DIV8_MAX  = 11'h400;
    localparam logic [10:0]        FRAC_MIN  = 11'h010;
    localparam logic [9:0]         MULT8_MIN = 10'h010;
    localparam logic [9:0]         MULT8_MAX = 10'h200;
    localparam logic [6:0]         PRE_MIN   = 7'h01;
    localparam logic [6:0]         PRE_MAX   = 7'h6A;
    localparam logic [6:0]         DUTY_MIN  = 7'h01;
    localparam logic [6:0]         DUTY_MAX  = 7'h63;
    localparam logic signed [9:0]  PH_MAX    = 10'sh168;
    localparam logic signed [9:0]  PH_MIN    = 10'sh298;
    localparam logic [8:0]         FBPH_MAX  = 9'h168;
    localparam int                 DEG_TURN  = 360;
    localparam int                 PCT_FULL  = 100;

    // one derived output's static settings
    typedef struct packed {
        logic [3:0]  rsv;
        logic [9:0]  phase;
        logic [6:0]  duty;
        logic [10:0] div8;
    } cmpc_out_t;

    // feedback path settings
    typedef struct packed {
        logic [8:0] fbdeg;
        logic [6:0] prediv;
        logic [5:0] rsv;
        logic [9:0] mult8;
    } cmpc_fb_t;

    // configuration port request
    typedef struct packed {
        logic       access;
        logic       write;
        logic [6:0] addr;
    } cmpc_cfg_req_t;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam cmpc_out_t  OUT_RST  = '{rsv: 4'h0, phase: 10'h000, duty: 7'h32, div8: 11'h008};
    localparam cmpc_fb_t   FB_RST   = '{fbdeg: 9'h000, prediv: 7'h01, rsv: 6'h00, mult8: 10'h028};

    typedef enum logic {LK_ACQUIRE, LK_LOCKED} cmpc_lock_t;
    typedef enum logic {PS_IDLE, PS_BUSY} cmpc_ps_t;

endpackage

// ===== logic/cmpc_top.sv
// clock manager control: phase-shift handshake, lock and halt monitor, config read port, output dividers
// assumes pclk also serves as phase-adjust, config-port and oscillator tick clock; inputs synchronous
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module cmpc_top (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // dynamic phase adjust
    input  wire logic                    phase_adjust_go,
    input  wire logic                    phase_adjust_direction,
    output logic                         phase_adjust_complete,
    // configuration read port
    input  wire cmpc_pkg::cmpc_cfg_req_t cfg_req,
    output logic      [15:0]             cfg_read_data,
    output logic                         cfg_port_ack,
    // clock monitor inputs
    input  wire logic                    ref_clock_alive,
    input  wire logic                    fb_clock_alive,
    input  wire logic                    align_fault,
    input  wire logic                    ref_input_select,
    // clock and status outputs
    output logic      [6:0]              derived_clock_outputs,
    output logic      [3:0]              complementary_outputs,
    output logic                         feedback_output,
    output logic                         locked,
    output logic                         ref_clock_halted,
    output logic                         fb_clock_halted
);

    // registers
    logic [7:0]          ctrl_r;
    cmpc_pkg::cmpc_fb_t  fb_r;
    cmpc_pkg::cmpc_out_t out_r [cmpc_pkg::NUM_OUT];
    logic                pready_r;
    logic                pslverr_r;
    logic [31:0]         prdata_r;
    logic                cfg_ack_r;
    logic [15:0]         cfg_rd_r;
    cmpc_pkg::cmpc_lock_t lk_state_r;
    cmpc_pkg::cmpc_lock_t lk_state_nxt;
    logic [9:0]          lock_cnt_r;
    logic                locked_r;
    logic                ref_halt_r;
    logic                fb_halt_r;
    logic                sel_q_r;
    cmpc_pkg::cmpc_ps_t  ps_state_r;
    logic [9:0]          settle_r;
    logic                dir_r;
    logic                done_r;
    logic [11:0]         ps_wait_r;

    // sanitise an output word into its legal ranges
    function automatic cmpc_pkg::cmpc_out_t legal_out(input logic first, input logic [31:0] w);
        cmpc_pkg::cmpc_out_t o;
        o     = cmpc_pkg::cmpc_out_t'(w);
        o.rsv = 4'h0;
        if (!first || o.div8 < cmpc_pkg::FRAC_MIN) o.div8[2:0] = 3'h0;
        if (o.div8 < cmpc_pkg::DIV8_MIN) o.div8 = cmpc_pkg::DIV8_MIN;
        else if (o.div8 > cmpc_pkg::DIV8_MAX) o.div8 = cmpc_pkg::DIV8_MAX;
        if (o.duty < cmpc_pkg::DUTY_MIN) o.duty = cmpc_pkg::DUTY_MIN;
        else if (o.duty > cmpc_pkg::DUTY_MAX) o.duty = cmpc_pkg::DUTY_MAX;
        if ($signed(o.phase) > cmpc_pkg::PH_MAX) o.phase = cmpc_pkg::PH_MAX;
        else if ($signed(o.phase) < cmpc_pkg::PH_MIN) o.phase = cmpc_pkg::PH_MIN;
        return o;
    endfunction

    // sanitise the feedback word
    function automatic cmpc_pkg::cmpc_fb_t legal_fb(input logic [31:0] w);
        cmpc_pkg::cmpc_fb_t f;
        f     = cmpc_pkg::cmpc_fb_t'(w);
        f.rsv = 6'h00;
        if (f.mult8 < cmpc_pkg::MULT8_MIN) f.mult8 = cmpc_pkg::MULT8_MIN;
        else if (f.mult8 > cmpc_pkg::MULT8_MAX) f.mult8 = cmpc_pkg::MULT8_MAX;
        if (f.prediv < cmpc_pkg::PRE_MIN) f.prediv = cmpc_pkg::PRE_MIN;
        else if (f.prediv > cmpc_pkg::PRE_MAX) f.prediv = cmpc_pkg::PRE_MAX;
        if (f.fbdeg > cmpc_pkg::FBPH_MAX) f.fbdeg = cmpc_pkg::FBPH_MAX;
        return f;
    endfunction

    // level of one channel from its counter, offsets and high fraction
    function automatic logic chan_high(input logic [10:0] per, input logic [10:0] cnt, input logic [10:0] acc,
                                       input logic signed [9:0] deg, input logic [8:0] fbdeg, input logic [6:0] duty);
        int p;
        int s;
        int f;
        int pos;
        int hi;
        p   = int'(per);
        s   = (p * int'(deg)) / cmpc_pkg::DEG_TURN;
        if (s < 0) s = s + p;
        f   = (p * int'(fbdeg)) / cmpc_pkg::DEG_TURN;
        pos = (int'(cnt) + 3 * p - s - int'(acc) + f) % p;
        if (pos < 0) pos = pos + p;
        hi  = (p * int'(duty)) / cmpc_pkg::PCT_FULL;
        if (hi < 1) hi = 1;
        return pos < hi;
    endfunction

    // apb decode: one wait state, write lands on the completing edge
    wire logic       apb_start = psel & penable & ~pready_r;
    wire logic       apb_wr    = psel & penable & pready_r & pwrite;
    wire logic [9:0] widx      = paddr[11:2];
    wire logic       aligned   = (paddr[1:0] == 2'h0);
    wire logic       hit_ctrl  = aligned & (paddr == cmpc_pkg::ADDR_CTRL);
    wire logic       hit_stat  = aligned & (paddr == cmpc_pkg::ADDR_STATUS);
    wire logic       hit_fb    = aligned & (paddr == cmpc_pkg::ADDR_FB);
    wire logic       hit_out   = aligned & (paddr >= cmpc_pkg::ADDR_OUT0) & (paddr <= cmpc_pkg::ADDR_OUT6);
    wire logic [2:0] oidx      = 3'(widx - cmpc_pkg::ADDR_OUT0[11:2]);
    wire logic       mapped    = hit_ctrl | hit_stat | hit_fb | hit_out;
    wire logic [7:0] pend_w;
    wire logic       ps_busy   = (ps_state_r == cmpc_pkg::PS_BUSY);
    wire logic [31:0] stat_w   = {16'h0000, pend_w, 4'h0, ps_busy, fb_halt_r, ref_halt_r, locked_r};
    wire logic [31:0] rd_word  = hit_ctrl ? {24'h000000, ctrl_r} :
                                 hit_stat ? stat_w :
                                 hit_fb   ? 32'(fb_r) :
                                 hit_out  ? 32'(out_r[oidx]) : 32'h00000000;

    // apb handshake and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= apb_start;
            pslverr_r <= apb_start & ~mapped;
            if (apb_start) prdata_r <= pwrite ? 32'h00000000 : rd_word;
        end
    end

    // register writes, ranges enforced on the way in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= cmpc_pkg::CTRL_RST;
            fb_r   <= cmpc_pkg::FB_RST;
            for (int i = 0; i < cmpc_pkg::NUM_OUT; i++) out_r[i] <= cmpc_pkg::OUT_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) ctrl_r <= pwdata[7:0];
            if (hit_fb) fb_r <= legal_fb(pwdata);
            if (hit_out) out_r[oidx] <= legal_out(oidx == 3'h0, pwdata);
        end
    end

    // lock monitor: any fault drops lock at the next edge, clean input relocks unaided
    wire logic lock_fault = ~ref_clock_alive | ~fb_clock_alive | align_fault
                            | (ref_input_select != sel_q_r) | (apb_wr & hit_fb);
    always_comb begin
        lk_state_nxt = lk_state_r;
        unique case (lk_state_r)
            cmpc_pkg::LK_ACQUIRE: if (!lock_fault && lock_cnt_r == 10'(cmpc_pkg::LOCK_CYC - 1))
                                      lk_state_nxt = cmpc_pkg::LK_LOCKED;
            cmpc_pkg::LK_LOCKED:  if (lock_fault) lk_state_nxt = cmpc_pkg::LK_ACQUIRE;
        endcase
    end

    // lock counter and halt flags; a stop sets a flag even while lock returns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_state_r <= cmpc_pkg::LK_ACQUIRE;
            lock_cnt_r <= 10'h000;
            locked_r   <= 1'b0;
            ref_halt_r <= 1'b0;
            fb_halt_r  <= 1'b0;
            sel_q_r    <= 1'b1;
        end else begin
            lk_state_r <= lk_state_nxt;
            lock_cnt_r <= (lock_fault || lk_state_r == cmpc_pkg::LK_LOCKED) ? 10'h000 : lock_cnt_r + 10'h001;
            locked_r   <= (lk_state_nxt == cmpc_pkg::LK_LOCKED);
            ref_halt_r <= ~ref_clock_alive | (ref_halt_r & ~locked_r);
            fb_halt_r  <= ~fb_clock_alive | (fb_halt_r & ~locked_r);
            sel_q_r    <= ref_input_select;
        end
    end

    // phase-adjust sequencer: go taken only when idle, complete after every step has landed
    wire logic go_take  = phase_adjust_go & ~ps_busy;
    wire logic ps_final = ps_busy & (pend_w == 8'h00) & (settle_r >= 10'(cmpc_pkg::PS_SETTLE_CYC - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_state_r <= cmpc_pkg::PS_IDLE;
            settle_r   <= 10'h000;
            dir_r      <= 1'b0;
            done_r     <= 1'b0;
        end else begin
            done_r <= ps_final;
            if (go_take) begin
                ps_state_r <= cmpc_pkg::PS_BUSY;
                settle_r   <= 10'h000;
                dir_r      <= phase_adjust_direction;
            end else if (ps_final) begin
                ps_state_r <= cmpc_pkg::PS_IDLE;
            end else if (ps_busy) begin
                settle_r <= settle_r + 10'h001;
            end
        end
    end

    // per-channel divider, dynamic offset and output stage; channel 7 is the feedback path
    wire logic [6:0] high_w;
    wire logic [3:0] low_w;
    wire logic       fb_high_w;
    for (genvar ch = 0; ch < cmpc_pkg::NUM_CH; ch++) begin : g_ch
        localparam bit IS_FB = (ch == cmpc_pkg::NUM_OUT);
        localparam int OI    = IS_FB ? 0 : ch;
        logic [10:0] cnt_r;
        logic [10:0] acc_r;
        logic        pend_r;
        logic        high_r;
        logic        low_r;
        wire logic [10:0]       per   = IS_FB ? {1'b0, fb_r.mult8} : out_r[OI].div8;
        wire logic              frac  = (per[2:0] != 3'h0);
        wire logic signed [9:0] deg   = IS_FB ? $signed({1'b0, fb_r.fbdeg}) : $signed(out_r[OI].phase);
        wire logic [8:0]        fbdeg = IS_FB ? 9'h000 : fb_r.fbdeg;
        wire logic [6:0]        duty  = IS_FB ? 7'h32 : out_r[OI].duty;
        wire logic              wrap  = (cnt_r >= per - 11'h001);
        wire logic              step  = pend_r & (wrap | ~locked_r);
        wire logic [10:0]       acc_up = (acc_r >= per - 11'h001) ? 11'h000 : acc_r + 11'h001;
        wire logic [10:0]       acc_dn = (acc_r == 11'h000 || acc_r >= per) ? per - 11'h001 : acc_r - 11'h001;
        wire logic              lvl   = chan_high(per, cnt_r, acc_r, deg, fbdeg, duty);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r  <= 11'h000;
                acc_r  <= 11'h000;
                pend_r <= 1'b0;
                high_r <= 1'b0;
                low_r  <= 1'b0;
            end else begin
                cnt_r  <= (!locked_r || wrap) ? 11'h000 : cnt_r + 11'h001;
                pend_r <= (go_take & ctrl_r[ch] & ~frac) | (pend_r & ~step);
                if (step) acc_r <= dir_r ? acc_up : acc_dn;
                high_r <= locked_r & lvl;
                low_r  <= locked_r & ~lvl;
            end
        end
        assign pend_w[ch] = pend_r;
        if (IS_FB) begin : g_fb
            assign fb_high_w = high_r;
        end else begin : g_out
            assign high_w[ch] = high_r;
            if (ch < cmpc_pkg::NUM_INV) begin : g_inv
                assign low_w[ch] = low_r;
            end
        end
    end

    // config port: read cells are halves of the register words, acknowledge one cycle later
    wire logic [3:0]  cell_word = cfg_req.addr[4:1];
    wire logic [31:0] cell_src  = (cell_word == 4'h0) ? {24'h000000, ctrl_r} :
                                  (cell_word == 4'h1) ? 32'(fb_r) :
                                  (cell_word <= 4'h8 && cfg_req.addr[6:5] == 2'h0) ?
                                      32'(out_r[3'(cell_word - 4'h2)]) : 32'h00000000;
    wire logic [15:0] cell_data = cfg_req.addr[0] ? cell_src[31:16] : cell_src[15:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ack_r <= 1'b0;
            cfg_rd_r  <= 16'h0000;
        end else begin
            cfg_ack_r <= cfg_req.access;
            if (cfg_req.access && !cfg_req.write) cfg_rd_r <= cell_data;
        end
    end

    // outputs, each straight from a flip-flop
    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;
    assign phase_adjust_complete = done_r;
    assign cfg_read_data         = cfg_rd_r;
    assign cfg_port_ack          = cfg_ack_r;
    assign derived_clock_outputs = high_w;
    assign complementary_outputs = low_w;
    assign feedback_output       = fb_high_w;
    assign locked                = locked_r;
    assign ref_clock_halted      = ref_halt_r;
    assign fb_clock_halted       = fb_halt_r;

    // helper: cycles spent in one adjustment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ps_wait_r <= 12'h000;
        else ps_wait_r <= ps_busy ? ps_wait_r + 12'h001 : 12'h000;
    end

    sequence go_seq;
        phase_adjust_go && !ps_busy;
    endsequence

    lock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_fault |=> !locked) else $error("lock stayed high after a fault");
    power_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lk_state_r == cmpc_pkg::LK_ACQUIRE && lock_cnt_r == 10'(cmpc_pkg::LOCK_CYC - 1) && !lock_fault)
        |=> locked) else $error("lock not acquired after count");
    ref_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ref_clock_alive |=> ref_clock_halted ##0 !locked) else $error("ref halt flag late");
    ref_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ref_clock_halted && !locked |=> ref_clock_halted) else $error("ref halt cleared without lock");
    fb_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fb_clock_alive |=> fb_clock_halted) else $error("fb halt flag late");
    done_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(phase_adjust_complete) |=> !phase_adjust_complete) else $error("complete wider than one cycle");
    done_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        ps_wait_r < 12'(cmpc_pkg::PS_WAIT_MAX)) else $error("adjustment never completed");
    done_after_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_seq |=> ps_busy ##1 !phase_adjust_complete) else $error("complete came too early");
    fine_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_seq and !ctrl_r[1] |=> !pend_w[1]) else $error("step queued on disabled channel");
    frac_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_seq and g_ch[0].frac |=> !pend_w[0]) else $error("step queued on fractional output");
    comp_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(locked) |-> complementary_outputs == ~derived_clock_outputs[3:0]) else $error("inverted copy wrong");
    cfg_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_req.access |=> cfg_port_ack) else $error("no acknowledge after strobe");
    cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_req.access && !cfg_req.write |=> cfg_read_data == $past(cell_data)) else $error("read data wrong");
    cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_req.access |=> $stable(cfg_read_data)) else $error("read data moved between operations");
    acc_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        g_ch[1].step && dir_r && g_ch[1].acc_r == g_ch[1].per - 11'h001 |=> g_ch[1].acc_r == 11'h000)
        else $error("offset did not wrap");

endmodule

// ===== testbench/cmpc_fab_model.sv
// fabric model: drives the phase-adjust and config-port handshakes
// assumes both ports run on pclk, inputs taken on its rising edge
`timescale 1ns/1ps
module cmpc_fab_model (
    // clock
    input  wire logic               pclk,
    // answers from the block
    input  wire logic               complete,
    input  wire logic               ack,
    input  wire logic [15:0]        rdata,
    // requests to the block
    output logic                    go,
    output logic                    dir,
    output cmpc_pkg::cmpc_cfg_req_t req
);
    // idle levels at time zero
    initial begin
        go = 1'b0;
        dir = 1'b0;
        req = '0;
    end
    // one go strobe, then wait for the complete pulse
    task automatic shift(input logic d, output logic seen);
        seen = 1'b0;
        @(posedge pclk);
        go  <= 1'b1;
        dir <= d;
        @(posedge pclk);
        go  <= 1'b0;
        dir <= ~d;
        for (int i = 0; i < 1100 && !seen; i++) begin
            @(posedge pclk);
            seen = (complete === 1'b1);
        end
    endtask
    // read one cell, taken at the edge where ack is high
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int i;
        @(posedge pclk);
        req <= '{access: 1'b1, write: 1'b0, addr: a};
        @(posedge pclk);
        req <= '{access: 1'b0, write: 1'b0, addr: ~a};
        // ack is read before this edge's updates land, i.e. as the edge sampled it
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (ack !== 1'b1 && i < 4);
        d = rdata;
    endtask
endmodule

// ===== testbench/cmpc_top_tb_top.sv
// bench: apb register access, lock, config reads, phase shifts, clock faults
// assumes a 10 MHz pclk and the fabric model on the user ports
`timescale 1ns/1ps
module cmpc_top_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, go, dir, complete, ack, fbo, locked, rh, fh, e, s;
    logic        ra = 1'b1, fa = 1'b1, flt = 1'b0, sel = 1'b0;
    logic [15:0] rdat, c;
    logic [6:0]  dco;
    logic [3:0]  cpo;
    int          n_errors = 0, cmp_count = 0;
    cmpc_pkg::cmpc_cfg_req_t req;
    // clock
    always #50 pclk = ~pclk;
    cmpc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_adjust_go(go), .phase_adjust_direction(dir), .phase_adjust_complete(complete),
        .cfg_req(req), .cfg_read_data(rdat), .cfg_port_ack(ack), .ref_clock_alive(ra),
        .fb_clock_alive(fa), .align_fault(flt), .ref_input_select(sel), .derived_clock_outputs(dco),
        .complementary_outputs(cpo), .feedback_output(fbo), .locked(locked),
        .ref_clock_halted(rh), .fb_clock_halted(fh));
    cmpc_fab_model fab_u (.pclk(pclk), .complete(complete), .ack(ack), .rdata(rdat), .go(go),
        .dir(dir), .req(req));
    task automatic chk(input logic [31:0] v, input logic [31:0] x);
        cmp_count++;
        if (v !== x) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, v, x);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read as the edge sampled it; request stands until then
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 8);
        if (pready !== 1'b1) n_errors++;
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_lock();
        for (int i = 0; i < 1200 && locked !== 1'b1; i++) @(posedge pclk);
        chk(locked, 1'b1);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #1_000_000;
        n_errors++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cmpc_pkg::ADDR_CTRL, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, cmpc_pkg::ADDR_FB, 32'h0, r, e);
        chk(r, 32'h0001_0028);
        apb(1'b0, cmpc_pkg::ADDR_OUT0, 32'h0, r, e);
        chk(r, 32'h0001_9008);
        wait_lock();
        apb(1'b0, 12'h0FC, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 1'b1);
        $display("test reset done");
        fab_u.rd(7'h02, c);
        chk(c, 16'h0028);
        fab_u.rd(7'h03, c);
        repeat (3) @(posedge pclk);
        chk(rdat, 16'h0001);
        $display("test config done");
        apb(1'b1, cmpc_pkg::ADDR_CTRL, 32'h1, r, e);
        for (int d = 0; d < 2; d++) begin
            fab_u.shift(d[0], s);
            chk(s, 1'b1);
            @(posedge pclk);
            chk(complete, 1'b0);
        end
        apb(1'b0, cmpc_pkg::ADDR_STATUS, 32'h0, r, e);
        chk(r[3:0], 4'h1);
        chk(cpo, 4'(~dco[3:0]));
        $display("test shift done");
        for (int i = 0; i < 2; i++) begin
            if (i == 0) ra <= 1'b0;
            else fa <= 1'b0;
            repeat (2) @(posedge pclk);
            chk({locked, rh, fh}, (i == 0) ? 3'b010 : 3'b001);
            ra <= 1'b1;
            fa <= 1'b1;
            repeat (2) @(posedge pclk);
            chk(rh | fh, 1'b1);
            wait_lock();
            repeat (2) @(posedge pclk);
            chk({rh, fh}, 2'b00);
            // lock fell in this test, so the unit is reset and must relock
            presetn <= 1'b0;
            @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            chk({locked, rh, fh}, 3'b000);
            wait_lock();
        end
        $display("test fault done");
        test_done();
    end
endmodule
